// >>> common/rtc_pkg.sv
// constants and carriers for the clockwatch load, year and prescaler block
// assumes a 32-bit avalon-mm register port and a 32 kHz slow clock pin

package rtc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CAL_PRESET_OFS  = 8'h08;
  localparam logic [7:0] YEAR_CUR_OFS    = 8'h0c;
  localparam logic [7:0] YEAR_MATCH_OFS  = 8'h10;
  localparam logic [7:0] YEAR_PRESET_OFS = 8'h14;
  localparam logic [7:0] CTRL_OFS        = 8'h18;

  // ==========================================================
  // field layouts and reset values
  localparam int YEAR_W = 14;
  localparam int FACTOR_W = 15;
  localparam int TRIM_W = 10;

  typedef struct packed {
    logic [2:0] rsvd;
    logic [3:0] preset_month;
    logic [4:0] preset_monthday;
    logic [2:0] preset_weekday;
    logic [4:0] preset_hours;
    logic [5:0] preset_minutes;
    logic [5:0] preset_seconds;
  } calendar_t;

  typedef struct packed {
    logic [4:0]          rsvd_hi;
    logic                calendar_enable_lock;
    logic [TRIM_W-1:0]   trim_pulse_count;
    logic                rsvd_lo;
    logic [FACTOR_W-1:0] prescale_factor;
  } ctrl_t;

  localparam logic [31:0] CAL_MASK = 32'h1fff_ffff;
  localparam logic [31:0] YEAR_MASK = 32'h0000_3fff;
  localparam logic [31:0] CTRL_MASK = 32'h07ff_7fff;
  localparam logic [31:0] CAL_RESET = 32'h0000_0000;
  localparam logic [YEAR_W-1:0] YEAR_RESET = 14'h2000;
  localparam logic [YEAR_W-1:0] YEAR_PRESET_RESET = 14'h0000;
  localparam logic [FACTOR_W-1:0] FACTOR_RESET = 15'h7fff;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 10'h000;

  // trim window spans 1023 slow cycles: counts 0 to 1022
  localparam logic [TRIM_W-1:0] TRIM_WIN_LAST = 10'h3fe;

  // ==========================================================
  // byte lane merge for avalon writes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// >>> design/bcd_digit.sv
// one bcd digit of the running year counter, with load and carry
// assumes load and increment come from logic on the same clock

`timescale 1ns/100ps

module bcd_digit #(
  parameter int          W     = 4,
  parameter logic [3:0]  LAST  = 4'h9,
  parameter logic [3:0]  RESET = 4'h0
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         inc_i,
  output logic [W-1:0]      digit_o,
  output logic              carry_o
);

  logic [W-1:0] digit_q;

  // carry on the last code lets the digit wrap to zero
  assign carry_o = inc_i && (digit_q == LAST[W-1:0]);
  assign digit_o = digit_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      digit_q <= RESET[W-1:0];
    end else if (load_i) begin
      digit_q <= load_val_i;
    end else if (carry_o) begin
      digit_q <= '0;
    end else if (inc_i) begin
      digit_q <= digit_q + W'(1);
    end
  end

endmodule

// >>> design/rtc_clockwatch.sv
// clockwatch presets, year counter and slow clock prescaler with trim
// assumes avalon-mm with waitrequest on clk_i and a free 32 kHz pin

`timescale 1ns/100ps

module rtc_clockwatch (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic [7:0]        address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [31:0]       writedata_i,
  input  wire logic [3:0]        byteenable_i,
  output logic [31:0]            readdata_o,
  output logic                   waitrequest_o,
  input  wire logic              slow_clock_i,
  input  wire logic              year_advance_i,
  output logic                   one_hz_tick_o,
  output logic                   timer_ref_o,
  output logic                   calendar_load_o,
  output logic                   clockwatch_enabled_o,
  output logic                   year_match_o,
  output rtc_pkg::calendar_t     preset_o,
  output logic [13:0]            current_year_o
);

  // ==========================================================
  // bus slave
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        wr_go;
  logic        rd_go;

  // every access answers after one wait state
  assign wr_go = write_i && !wait_q;
  assign rd_go = read_i && !wait_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_q <= 1'b1;
    end else if ((read_i || write_i) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign waitrequest_o = wait_q;
  assign readdata_o = rdata_q;

  // ==========================================================
  // registers
  rtc_pkg::calendar_t   cal_q;
  rtc_pkg::ctrl_t       ctrl_q;
  rtc_pkg::ctrl_t       ctrl_wr;
  logic [13:0]          year_cmp_q;
  logic [13:0]          year_pre_q;
  logic [13:0]          year_cur;
  logic                 lock_prev_q;
  logic                 load_go;

  assign ctrl_wr = rtc_pkg::ctrl_t'(rtc_pkg::be_merge(ctrl_q, writedata_i, byteenable_i)
                                    & rtc_pkg::CTRL_MASK);

  // weekday and month codes are stored as written; the device trusts software
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cal_q <= rtc_pkg::CAL_RESET;
    end else if (wr_go && address_i == rtc_pkg::CAL_PRESET_OFS) begin
      cal_q <= rtc_pkg::calendar_t'(rtc_pkg::be_merge(cal_q, writedata_i, byteenable_i)
                                    & rtc_pkg::CAL_MASK);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      year_cmp_q <= rtc_pkg::YEAR_RESET;
    end else if (wr_go && address_i == rtc_pkg::YEAR_MATCH_OFS) begin
      year_cmp_q <= rtc_pkg::YEAR_W'(rtc_pkg::be_merge(32'(year_cmp_q), writedata_i,
                                                       byteenable_i));
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      year_pre_q <= rtc_pkg::YEAR_PRESET_RESET;
    end else if (wr_go && address_i == rtc_pkg::YEAR_PRESET_OFS) begin
      year_pre_q <= rtc_pkg::YEAR_W'(rtc_pkg::be_merge(32'(year_pre_q), writedata_i,
                                                       byteenable_i));
    end
  end

  // once locked nothing in the control word moves until power-on reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= '0;
      ctrl_q.prescale_factor <= rtc_pkg::FACTOR_RESET;
      ctrl_q.trim_pulse_count <= rtc_pkg::TRIM_RESET;
    end else if (wr_go && address_i == rtc_pkg::CTRL_OFS && !ctrl_q.calendar_enable_lock) begin
      ctrl_q <= ctrl_wr;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= '0;
    end else if (read_i && wait_q) begin
      case (address_i)
        rtc_pkg::CAL_PRESET_OFS:  rdata_q <= cal_q & rtc_pkg::CAL_MASK;
        rtc_pkg::YEAR_CUR_OFS:    rdata_q <= 32'(year_cur);
        rtc_pkg::YEAR_MATCH_OFS:  rdata_q <= 32'(year_cmp_q);
        rtc_pkg::YEAR_PRESET_OFS: rdata_q <= 32'(year_pre_q);
        rtc_pkg::CTRL_OFS:        rdata_q <= ctrl_q & rtc_pkg::CTRL_MASK;
        default:                  rdata_q <= '0;
      endcase
    end
  end

  // ==========================================================
  // enable edge and preset load
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= ctrl_q.calendar_enable_lock;
    end
  end

  assign load_go = ctrl_q.calendar_enable_lock && !lock_prev_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      calendar_load_o <= 1'b0;
    end else begin
      calendar_load_o <= load_go;
    end
  end

  assign preset_o = cal_q;
  assign clockwatch_enabled_o = ctrl_q.calendar_enable_lock;

  // ==========================================================
  // running year, bcd digits 3999 wraps to 0
  // padded so the top two-bit digit never slices past the 14-bit reset value
  localparam logic [15:0] YEAR_RESET_PAD = 16'(rtc_pkg::YEAR_RESET);
  logic [4:0] carry;

  assign carry[0] = year_advance_i && ctrl_q.calendar_enable_lock && !load_go;

  for (genvar g = 0; g < 4; g++) begin : g_digit
    localparam int DW = (g == 3) ? 2 : 4;
    localparam logic [3:0] DL = (g == 3) ? 4'h3 : 4'h9;
    localparam logic [3:0] DR = YEAR_RESET_PAD[g*4 +: 4];
    bcd_digit #(
      .W     (DW),
      .LAST  (DL),
      .RESET (DR)
    ) u_digit (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .load_i     (load_go),
      .load_val_i (year_pre_q[g*4 +: DW]),
      .inc_i      (carry[g]),
      .digit_o    (year_cur[g*4 +: DW]),
      .carry_o    (carry[g+1])
    );
  end

  assign current_year_o = year_cur;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      year_match_o <= 1'b0;
    end else begin
      year_match_o <= (year_cur == year_cmp_q);
    end
  end

  // ==========================================================
  // slow clock pin: two flops, then edge detect on the second
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic slow_tick;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= slow_clock_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign slow_tick = sync2_q && !sync3_q;

  // ==========================================================
  // trim: the first n slow ticks of each 1023-tick window are dropped
  logic [9:0] trim_win_q;
  logic       trim_drop;
  logic       eff_tick;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      trim_win_q <= '0;
    end else if (slow_tick) begin
      if (trim_win_q == rtc_pkg::TRIM_WIN_LAST) begin
        trim_win_q <= '0;
      end else begin
        trim_win_q <= trim_win_q + 10'h001;
      end
    end
  end

  assign trim_drop = trim_win_q < ctrl_q.trim_pulse_count;
  assign eff_tick = slow_tick && !trim_drop;

  // ==========================================================
  // prescaler: reload with the factor, tick when the count is spent
  logic [14:0] div_q;
  logic        factor_zero;

  assign factor_zero = ctrl_q.prescale_factor == '0;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_q <= rtc_pkg::FACTOR_RESET;
    end else if (eff_tick) begin
      if (div_q == '0) begin
        div_q <= ctrl_q.prescale_factor;
      end else begin
        div_q <= div_q - 15'h0001;
      end
    end
  end

  // the clockwatch reference halts on a zero factor; the timer then sees every tick that trim keeps
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      one_hz_tick_o <= 1'b0;
      timer_ref_o <= 1'b0;
    end else begin
      one_hz_tick_o <= eff_tick && div_q == '0 && !factor_zero;
      timer_ref_o <= eff_tick && (factor_zero || div_q == '0);
    end
  end

  // ==========================================================
  // checks
  property p_year_bcd;
    @(posedge clk_i) disable iff (reset_i)
    year_cur[3:0] <= 4'h9 && year_cur[7:4] <= 4'h9 && year_cur[11:8] <= 4'h9;
  endproperty
  a_year_bcd: assert property (p_year_bcd) else $error("year digit out of bcd range");

  property p_year_wrap;
    @(posedge clk_i) disable iff (reset_i)
    (carry[0] && !load_go && year_cur == 14'h3999) |=> year_cur == 14'h0000;
  endproperty
  a_year_wrap: assert property (p_year_wrap) else $error("year did not wrap to zero");

  property p_match;
    @(posedge clk_i) disable iff (reset_i)
    !$past(reset_i) |-> year_match_o == ($past(year_cur) == $past(year_cmp_q));
  endproperty
  a_match: assert property (p_match) else $error("year match flag wrong");

  property p_load;
    @(posedge clk_i) disable iff (reset_i)
    load_go |=> year_cur == $past(year_pre_q) && calendar_load_o;
  endproperty
  a_load: assert property (p_load) else $error("preset year not loaded on enable");

  property p_divide;
    @(posedge clk_i) disable iff (reset_i)
    (eff_tick && div_q == '0 && !factor_zero) |=> one_hz_tick_o && div_q == $past(ctrl_q.prescale_factor);
  endproperty
  a_divide: assert property (p_divide) else $error("prescaler did not tick and reload");

  property p_zero_factor;
    @(posedge clk_i) disable iff (reset_i)
    (factor_zero && eff_tick) |=> timer_ref_o && !one_hz_tick_o;
  endproperty
  a_zero_factor: assert property (p_zero_factor) else $error("zero factor reference wrong");

  property p_trim;
    @(posedge clk_i) disable iff (reset_i)
    (slow_tick && trim_win_q < ctrl_q.trim_pulse_count) |=> !timer_ref_o && !one_hz_tick_o;
  endproperty
  a_trim: assert property (p_trim) else $error("trimmed pulse reached the prescaler");

  property p_locked;
    @(posedge clk_i) disable iff (reset_i)
    (ctrl_q.calendar_enable_lock && wr_go && address_i == rtc_pkg::CTRL_OFS) |=> $stable(ctrl_q);
  endproperty
  a_locked: assert property (p_locked) else $error("control changed while locked");

  property p_lock_holds;
    @(posedge clk_i) disable iff (reset_i)
    ctrl_q.calendar_enable_lock |=> ctrl_q.calendar_enable_lock [*3];
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("enable lock released");

  property p_reserved;
    @(posedge clk_i) disable iff (reset_i)
    (rd_go && address_i == rtc_pkg::YEAR_CUR_OFS) |-> readdata_o[31:14] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

endmodule

// >>> tb/rtc_clockwatch_tb_top.sv
// self-checking bench for the clockwatch preset, year and prescaler block
// assumes the bench is the only avalon master and drives the slow clock pin itself
`timescale 1ns/100ps

module rtc_clockwatch_tb_top;
  logic               clk_i;
  logic               reset_i;
  logic [7:0]         address_i;
  logic               read_i;
  logic               write_i;
  logic [31:0]        writedata_i;
  logic [3:0]         byteenable_i;
  logic [31:0]        readdata_o;
  logic               waitrequest_o;
  logic               slow_clock_i;
  logic               year_advance_i;
  logic               one_hz_tick_o;
  logic               timer_ref_o;
  logic               calendar_load_o;
  logic               clockwatch_enabled_o;
  logic               year_match_o;
  rtc_pkg::calendar_t preset_o;
  logic [13:0]        current_year_o;
  logic [31:0]        exp_q[$];
  int                 bad_count = 0;
  int                 n_checks = 0;
  int                 n_hz = 0;
  int                 n_ref = 0;
  int                 n_load = 0;
  int                 seed = 32'hfd63;

  rtc_clockwatch rtc_clockwatch_inst (.clk_i(clk_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .slow_clock_i(slow_clock_i), .year_advance_i(year_advance_i),
    .one_hz_tick_o(one_hz_tick_o), .timer_ref_o(timer_ref_o), .calendar_load_o(calendar_load_o),
    .clockwatch_enabled_o(clockwatch_enabled_o), .year_match_o(year_match_o), .preset_o(preset_o),
    .current_year_o(current_year_o));

  // ==========================================================
  // clock and report
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_count(input int got, input int exp, input string what);
    n_checks++;
    if (got != exp) begin
      bad_count++;
      $display("mismatch at %0t: %s count %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // ==========================================================
  // monitor: read data and pulse counters
  always @(posedge clk_i) begin
    if (read_i === 1'b1 && waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("mismatch at %0t: read completed with no expectation", $time);
      end else begin
        chk_data(readdata_o, exp_q.pop_front(), "read data");
      end
    end
    if (one_hz_tick_o === 1'b1) n_hz++;
    if (timer_ref_o === 1'b1) n_ref++;
    if (calendar_load_o === 1'b1) n_load++;
  end

  // ==========================================================
  // drivers; every task is entered just after a rising edge
  task automatic bus_cycle(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    read_i <= rd;
    write_i <= ~rd;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    read_i <= 1'b0;
    write_i <= 1'b0;
    if (n >= 50) begin
      $display("mismatch at %0t: bus answer timed out", $time);
      bad_count++;
      wrap_up();
    end else begin
      // one idle edge so a following request is not raised in the same step
      @(posedge clk_i);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    bus_cycle(1'b0, a, d, be);
  endtask

  task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus_cycle(1'b1, a, 32'h0000_0000, 4'hf);
  endtask

  task automatic do_reset();
    reset_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    n_hz = 0;
    n_ref = 0;
    n_load = 0;
    @(posedge clk_i);
  endtask

  // fastest legal pin rate: one clk high, one low; drain covers sync latency
  task automatic run_ticks(input int n);
    for (int i = 0; i < n; i++) begin
      slow_clock_i <= 1'b1;
      @(posedge clk_i);
      slow_clock_i <= 1'b0;
      @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] cal;
    reset_i = 1'b1;
    address_i = 8'h00;
    read_i = 1'b0;
    write_i = 1'b0;
    writedata_i = 32'h0000_0000;
    byteenable_i = 4'h0;
    slow_clock_i = 1'b0;
    year_advance_i = 1'b0;
    do_reset();

    bus_read(rtc_pkg::CAL_PRESET_OFS, 32'h0000_0000);
    bus_read(rtc_pkg::YEAR_CUR_OFS, 32'h0000_2000);
    bus_read(rtc_pkg::YEAR_MATCH_OFS, 32'h0000_2000);
    bus_read(rtc_pkg::YEAR_PRESET_OFS, 32'h0000_0000);
    bus_read(rtc_pkg::CTRL_OFS, 32'h0000_7fff);
    bus_read(8'h04, 32'h0000_0000);
    chk_data({31'h0, year_match_o}, 32'h1, "match at reset year");
    $display("test reset values done");

    // every month and weekday code, random legal time fields, reserved bits set
    for (int m = 1; m <= 12; m++) begin
      cal = {3'b111, 4'(m), 5'(1 + unsigned'($random(seed)) % 28), 3'((m - 1) % 7 + 1),
             5'(unsigned'($random(seed)) % 24), 6'(unsigned'($random(seed)) % 60),
             6'(unsigned'($random(seed)) % 60)};
      bus_write(rtc_pkg::CAL_PRESET_OFS, cal);
      bus_read(rtc_pkg::CAL_PRESET_OFS, cal & 32'h1fff_ffff);
      chk_data(preset_o, cal & 32'h1fff_ffff, "preset port");
    end
    $display("test calendar preset done");

    bus_write(rtc_pkg::YEAR_CUR_OFS, 32'h0000_1234);
    bus_read(rtc_pkg::YEAR_CUR_OFS, 32'h0000_2000);
    bus_write(rtc_pkg::YEAR_MATCH_OFS, 32'hffff_3999);
    bus_read(rtc_pkg::YEAR_MATCH_OFS, 32'h0000_3999);
    bus_write(rtc_pkg::YEAR_MATCH_OFS, 32'h0000_0012, 4'h1);
    bus_read(rtc_pkg::YEAR_MATCH_OFS, 32'h0000_3912);
    bus_write(rtc_pkg::YEAR_PRESET_OFS, 32'hffff_1999);
    bus_read(rtc_pkg::YEAR_PRESET_OFS, 32'h0000_1999);
    $display("test year registers done");

    // factor 3 is taken at the reload that ends the reset count of 32768 ticks
    bus_write(rtc_pkg::CTRL_OFS, 32'hf800_8003);
    bus_read(rtc_pkg::CTRL_OFS, 32'h0000_0003);
    run_ticks(32771);
    chk_count(n_hz, 1, "one hz after 32771 ticks");
    run_ticks(1);
    chk_count(n_hz, 2, "one hz after 32772 ticks");
    chk_count(n_ref, 2, "timer ref with nonzero factor");
    $display("test prescale done");

    do_reset();
    bus_write(rtc_pkg::CTRL_OFS, 32'h0002_0000);
    bus_read(rtc_pkg::CTRL_OFS, 32'h0002_0000);
    run_ticks(1023);
    chk_count(n_ref, 1021, "kept ticks first window");
    run_ticks(3);
    chk_count(n_ref, 1022, "kept ticks second window");
    chk_count(n_hz, 0, "one hz stopped at factor zero");
    $display("test trim and factor zero done");

    do_reset();
    bus_write(rtc_pkg::YEAR_PRESET_OFS, 32'h0000_1999);
    bus_write(rtc_pkg::CTRL_OFS, 32'h0401_0005);
    repeat (3) @(posedge clk_i);
    chk_count(n_load, 1, "calendar load pulses");
    chk_data({18'h0, current_year_o}, 32'h0000_1999, "loaded year");
    chk_data({31'h0, clockwatch_enabled_o}, 32'h1, "enabled flag");
    chk_data({31'h0, year_match_o}, 32'h0, "match after load");
    bus_write(rtc_pkg::CTRL_OFS, 32'h0000_0007);
    bus_read(rtc_pkg::CTRL_OFS, 32'h0401_0005);
    year_advance_i <= 1'b1;
    @(posedge clk_i);
    year_advance_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_data({18'h0, current_year_o}, 32'h0000_2000, "year carry");
    chk_data({31'h0, year_match_o}, 32'h1, "match after carry");
    bus_read(rtc_pkg::YEAR_CUR_OFS, 32'h0000_2000);
    chk_count(n_load, 1, "no reload while locked");
    $display("test lock and load done");

    // top of the bcd range rolls over to zero on the next advance
    do_reset();
    bus_write(rtc_pkg::YEAR_PRESET_OFS, 32'h0000_3999);
    bus_write(rtc_pkg::CTRL_OFS, 32'h0400_7fff);
    year_advance_i <= 1'b1;
    @(posedge clk_i);
    year_advance_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_count(n_load, 1, "load before wrap");
    chk_data({18'h0, current_year_o}, 32'h0000_0000, "year wrap");
    bus_read(rtc_pkg::YEAR_CUR_OFS, 32'h0000_0000);
    $display("test year wrap done");
    wrap_up();
  end
endmodule
